// file: rtl/sqwb_top.sv
`timescale 1ns/100ps
// What this block does
// R1: Two independent 32-byte store queues, each configured on its own.
// R2: Stores with address bits 31:26 equal 111000 go into a queue.
// R3: Queue stores accept 32-bit and 64-bit sizes.
// R4: Bit 5 picks queue, bits 4:2 the word, bits 1:0 zero.
// R5: Prefetch to the queue region starts a burst of that queue.
// R6: Each burst moves 32 bytes from a 32-byte aligned address.
// R7: Other queue writes freely; writes to the busy queue wait.
// R8: Translated entry supplies the page; its attribute bits are ignored.
// R9: Translated address bits 28:10 by page size, 9:5 from virtual.
// R10: Untranslated bits 25:6 pass; bit 5 selects queue and address.
// R11: Prefetch bits 4:2 are ignored.
// R12: Untranslated bits 28:26 come from the queue's area control.
// R13: Card area bursts use the page table assistance attributes.
// R14: Area control registers unreachable while queues are powered down.
// R15: Exception on a transfer aborts it with no external write.
// R16: Exception on a queue write keeps old contents.
// R17: Writes checked as write, transfers as read, raising translation faults.
// R18: Privileged-only setting gives user an address error even when translated.
// R19: Untranslated: setting 0 allows all, 1 gives user address error.
// R20: Privileged word loads read queue contents in a separate region.
// R21: A 64-bit store fills an aligned even and odd word pair.
module sqwb_top (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Core operation port
    input wire logic opReq,
    input wire logic [1:0] opKind,
    input wire logic [31:0] opAddr,
    input wire logic [63:0] opData,
    input wire logic opQuad,
    input wire logic opUser,
    output logic opAck_r,
    output logic [2:0] opExc_r,
    output logic [31:0] opRdata_r,
    // Translation mode and lookup result for opAddr
    input wire logic mmuOn,
    input wire logic privOnly,
    input wire logic tlbHit,
    input wire logic [28:10] tlbPpn,
    input wire logic [1:0] tlbSize,
    input wire logic tlbWrOk,
    input wire logic tlbRdOk,
    input wire logic tlbDirty,
    // Card area attributes and power-down
    input wire logic [2:0] pteaSa,
    input wire logic pteaTc,
    input wire logic sqStopped,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata_r,
    // External memory burst
    output logic memReq_r,
    output logic [28:0] memAddr_r,
    output logic [63:0] memData_r,
    output logic memLast_r,
    output logic [2:0] memSa_r,
    output logic memTc_r,
    input wire logic memAck
);
    typedef enum logic [1:0] {X_IDLE, X_FETCH, X_SEND} sqwb_xst_t;

    typedef struct packed {
        sqwb_xst_t st;
        logic q;
        logic [1:0] beat;
        logic [28:5] base;
        logic [2:0] queue_zero_area_control;
        logic [2:0] queue_one_area_control;
        logic [31:0] rdata;
        logic ack;
        logic [2:0] exc;
        logic req;
        logic last;
        logic [2:0] sa;
        logic tc;
    } sqwb_state_t;

    sqwb_state_t s_r;
    sqwb_state_t s_nxt;

    logic sel;
    logic busy;
    logic inSq;
    logic inRb;
    logic hold;
    logic accept;
    logic wrEn;
    logic [1:0] wrLane;
    logic [63:0] wrData;
    logic [2:0] rdIdx;
    logic [28:5] extAddr;
    logic [2:0] xExc;
    logic [2:0] opExc;
    logic [2:0] areaHi;

    function automatic logic isCardArea(input logic [2:0] hi);
        return hi == sqwb_pkg::PCC_AREA5 || hi == sqwb_pkg::PCC_AREA6;
    endfunction : isCardArea

    assign sel = opAddr[sqwb_pkg::SQ_SEL_BIT];
    assign busy = s_r.st != X_IDLE;
    // R2: queue region decode
    assign inSq = opAddr[31:26] == sqwb_pkg::SQ_REGION;
    assign inRb = opAddr[31:6] == sqwb_pkg::RB_REGION;
    // R12: area control of selected queue
    assign areaHi = sel ? s_r.queue_one_area_control : s_r.queue_zero_area_control;

    // R7: stores are held only for the busy queue; any prefetch is held while busy
    always_comb begin
        hold = 1'b0;
        if (opReq && busy && opKind == sqwb_pkg::OP_STORE && sel == s_r.q) begin
            hold = 1'b1;
        end
        if (opReq && busy && opKind == sqwb_pkg::OP_PREFETCH_OP) begin
            hold = 1'b1;
        end
    end
    assign accept = opReq && !hold;

    sqwb_xlate u_xlate (
        .addr(opAddr),
        .isWrite(opKind == sqwb_pkg::OP_STORE),
        .isQuad(opQuad && opKind == sqwb_pkg::OP_STORE),
        .user(opUser),
        .mmuOn(mmuOn),
        .privOnly(privOnly),
        .areaHi(areaHi),
        .tlbHit(tlbHit),
        .tlbPpn(tlbPpn),
        .tlbSize(tlbSize),
        .tlbWrOk(tlbWrOk),
        .tlbRdOk(tlbRdOk),
        .tlbDirty(tlbDirty),
        .extAddr(extAddr),
        .exc(xExc)
    );

    always_comb begin
        if (opKind == sqwb_pkg::OP_LOAD) begin
            // R20: privileged aligned words only
            opExc = (!inRb || opUser || opAddr[1:0] != 2'h0) ? sqwb_pkg::EXC_ADDR : sqwb_pkg::EXC_NONE;
        end else if (!inSq || opKind != sqwb_pkg::OP_STORE && opKind != sqwb_pkg::OP_PREFETCH_OP) begin
            opExc = sqwb_pkg::EXC_ADDR;
        end else begin
            opExc = xExc;
        end
    end

    // R16: faulting stores never write
    assign wrEn = accept && opKind == sqwb_pkg::OP_STORE && opExc == sqwb_pkg::EXC_NONE;

    // R3: both sizes
    // R21: quad fills a word pair
    always_comb begin
        if (opQuad) begin
            wrLane = 2'h3;
            wrData = opData;
        end else begin
            wrLane = opAddr[2] ? 2'h2 : 2'h1;
            wrData = {opData[31:0], opData[31:0]};
        end
    end

    assign rdIdx = {s_r.q, s_r.beat};

    // R1: two queues in one array
    sqwb_queue_mem u_mem (
        .clock(clock),
        .wrEn(wrEn),
        .wrIdx({sel, opAddr[4:3]}),
        .wrLane(wrLane),
        .wrData(wrData),
        .rdIdx(rdIdx),
        .rdData_r(memData_r),
        .ldIdx(opAddr[5:2]),
        .ldData_r(opRdata_r)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = accept;
        s_nxt.exc = accept ? opExc : sqwb_pkg::EXC_NONE;
        // R5: prefetch starts a burst
        // R15: faulting prefetch never starts
        // R11: word bits dropped from start address
        if (accept && opKind == sqwb_pkg::OP_PREFETCH_OP && opExc == sqwb_pkg::EXC_NONE) begin
            s_nxt.st = X_FETCH;
            s_nxt.q = sel;
            s_nxt.beat = 2'h0;
            s_nxt.base = extAddr;
            // R13: card area attributes
            s_nxt.sa = isCardArea(extAddr[28:26]) ? pteaSa : sqwb_pkg::SA_RST;
            s_nxt.tc = isCardArea(extAddr[28:26]) ? pteaTc : 1'b0;
        end
        case (s_r.st)
            X_IDLE: begin
                s_nxt.req = 1'b0;
            end
            X_FETCH: begin
                s_nxt.req = 1'b1;
                s_nxt.last = s_r.beat == sqwb_pkg::BEAT_LAST;
                s_nxt.st = X_SEND;
            end
            X_SEND: begin
                // R6: four beats of eight bytes
                if (memAck) begin
                    s_nxt.req = 1'b0;
                    s_nxt.last = 1'b0;
                    if (s_r.beat == sqwb_pkg::BEAT_LAST) begin
                        s_nxt.st = X_IDLE;
                    end else begin
                        s_nxt.beat = s_r.beat + 2'h1;
                        s_nxt.st = X_FETCH;
                    end
                end
            end
            default: begin
                s_nxt.st = X_IDLE;
            end
        endcase
        // R14: area control gated by power-down
        if (regWr && !sqStopped && regAddr == sqwb_pkg::REG_QUEUE_ZERO_AREA_CONTROL) begin
            s_nxt.queue_zero_area_control = regWdata[sqwb_pkg::QACR_HI:sqwb_pkg::QACR_LO];
        end
        if (regWr && !sqStopped && regAddr == sqwb_pkg::REG_QUEUE_ONE_AREA_CONTROL) begin
            s_nxt.queue_one_area_control = regWdata[sqwb_pkg::QACR_HI:sqwb_pkg::QACR_LO];
        end
        s_nxt.rdata = 32'h0;
        if (regRd) begin
            case (regAddr)
                sqwb_pkg::REG_QUEUE_ZERO_AREA_CONTROL: s_nxt.rdata[sqwb_pkg::QACR_HI:sqwb_pkg::QACR_LO] = sqStopped ? 3'h0 : s_r.queue_zero_area_control;
                sqwb_pkg::REG_QUEUE_ONE_AREA_CONTROL: s_nxt.rdata[sqwb_pkg::QACR_HI:sqwb_pkg::QACR_LO] = sqStopped ? 3'h0 : s_r.queue_one_area_control;
                sqwb_pkg::REG_STATUS: s_nxt.rdata[1:0] = {busy, s_r.q};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        if (srst) begin
            s_nxt = '0;
            s_nxt.st = X_IDLE;
            s_nxt.queue_zero_area_control = sqwb_pkg::QACR_RST;
            s_nxt.queue_one_area_control = sqwb_pkg::QACR_RST;
        end
    end

    always_ff @(posedge clock) begin
        s_r <= s_nxt;
    end

    assign opAck_r = s_r.ack;
    assign opExc_r = s_r.exc;
    assign regRdata_r = s_r.rdata;
    assign memReq_r = s_r.req;
    // R6: low three bits forced zero
    // Beat offset sits in bits 4:3, so no adder between flop and pin
    assign memAddr_r = {s_r.base, s_r.beat, 3'h0};
    assign memLast_r = s_r.last;
    assign memSa_r = s_r.sa;
    assign memTc_r = s_r.tc;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_burst_start_align: assert property ( // R6
        memReq_r && s_r.beat == 2'h0 |-> memAddr_r[4:0] == 5'h0)
        else $error("burst start not aligned");

    a_burst_ends_last: assert property ( // R6
        memReq_r && memLast_r && memAck |=> !memReq_r ##1 !memReq_r)
        else $error("burst ran past four beats");

    a_busy_store_held: assert property ( // R7
        opReq && busy && opKind == sqwb_pkg::OP_STORE && sel == s_r.q |=> !opAck_r)
        else $error("store to busy queue taken");

    a_other_store_free: assert property ( // R7
        opReq && busy && opKind == sqwb_pkg::OP_STORE && sel != s_r.q |=> opAck_r)
        else $error("store to idle queue delayed");

    a_fault_no_burst: assert property ( // R15
        accept && opKind == sqwb_pkg::OP_PREFETCH_OP && opExc != sqwb_pkg::EXC_NONE && !busy
        |=> !memReq_r [*3])
        else $error("faulting prefetch wrote out");

    a_stopped_read_zero: assert property ( // R14
        regRd && sqStopped && regAddr != sqwb_pkg::REG_STATUS |=> regRdata_r == 32'h0)
        else $error("area control read while stopped");

    a_user_addr_err: assert property ( // R19
        accept && privOnly && opUser && inSq && opKind == sqwb_pkg::OP_STORE
        |=> opAck_r && opExc_r == sqwb_pkg::EXC_ADDR)
        else $error("user access not refused");

    a_prefetch_op_starts: assert property ( // R5
        accept && opKind == sqwb_pkg::OP_PREFETCH_OP && opExc == sqwb_pkg::EXC_NONE
        |=> !memReq_r ##1 memReq_r && memAddr_r[28:5] == $past(extAddr, 2))
        else $error("prefetch burst not started");
endmodule : sqwb_top

// file: rtl/sqwb_pkg.sv
package sqwb_pkg;
    // Address decode
    localparam logic [5:0] SQ_REGION = 6'h38;
    localparam logic [25:0] RB_REGION = 26'h3FC0040;
    localparam int SQ_SEL_BIT = 5;
    // Register port offsets
    localparam logic [3:0] REG_QUEUE_ZERO_AREA_CONTROL = 4'h0;
    localparam logic [3:0] REG_QUEUE_ONE_AREA_CONTROL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    // Area control field
    localparam int QACR_LO = 2;
    localparam int QACR_HI = 4;
    localparam logic [2:0] QACR_RST = 3'h0;
    // Operation kinds
    localparam logic [1:0] OP_STORE = 2'h0;
    localparam logic [1:0] OP_PREFETCH_OP = 2'h1;
    localparam logic [1:0] OP_LOAD = 2'h2;
    // Exception codes
    localparam logic [2:0] EXC_NONE = 3'h0;
    localparam logic [2:0] EXC_MISS = 3'h1;
    localparam logic [2:0] EXC_PROT = 3'h2;
    localparam logic [2:0] EXC_INIT = 3'h3;
    localparam logic [2:0] EXC_ADDR = 3'h4;
    // Page sizes
    localparam logic [1:0] SZ_1K = 2'h0;
    localparam logic [1:0] SZ_4K = 2'h1;
    localparam logic [1:0] SZ_64K = 2'h2;
    // Burst
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [2:0] PCC_AREA5 = 3'h5;
    localparam logic [2:0] PCC_AREA6 = 3'h6;
    localparam logic [2:0] SA_RST = 3'h0;
endpackage : sqwb_pkg

// file: rtl/sqwb_queue_mem.sv
`timescale 1ns/100ps
module sqwb_queue_mem (
    // Clock
    input wire logic clock,
    // Write port, one 64-bit entry per word pair
    input wire logic wrEn,
    input wire logic [2:0] wrIdx,
    input wire logic [1:0] wrLane,
    input wire logic [63:0] wrData,
    // Burst read port
    input wire logic [2:0] rdIdx,
    output logic [63:0] rdData_r,
    // Word read port
    input wire logic [3:0] ldIdx,
    output logic [31:0] ldData_r
);
    typedef struct packed {
        logic [7:0][63:0] mem;
        logic [63:0] rd;
        logic [31:0] ld;
    } sqwb_mem_t;

    sqwb_mem_t s_r;
    sqwb_mem_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wrEn && wrLane[0]) begin
            s_nxt.mem[wrIdx][31:0] = wrData[31:0];
        end
        if (wrEn && wrLane[1]) begin
            s_nxt.mem[wrIdx][63:32] = wrData[63:32];
        end
        s_nxt.rd = s_r.mem[rdIdx];
        s_nxt.ld = ldIdx[0] ? s_r.mem[ldIdx[3:1]][63:32] : s_r.mem[ldIdx[3:1]][31:0];
    end

    always_ff @(posedge clock) begin
        s_r <= s_nxt;
    end

    assign rdData_r = s_r.rd;
    assign ldData_r = s_r.ld;
endmodule : sqwb_queue_mem

// file: rtl/sqwb_xlate.sv
`timescale 1ns/100ps
module sqwb_xlate (
    // Access
    input wire logic [31:0] addr,
    input wire logic isWrite,
    input wire logic isQuad,
    input wire logic user,
    // Mode
    input wire logic mmuOn,
    input wire logic privOnly,
    input wire logic [2:0] areaHi,
    // Translation result
    input wire logic tlbHit,
    input wire logic [28:10] tlbPpn,
    input wire logic [1:0] tlbSize,
    input wire logic tlbWrOk,
    input wire logic tlbRdOk,
    input wire logic tlbDirty,
    // Result
    output logic [28:5] extAddr,
    output logic [2:0] exc
);
    function automatic logic [28:10] pageMix(input logic [28:10] physical_page_number, input logic [1:0] sz,
                                             input logic [31:0] va);
        logic [28:10] m;
        m = physical_page_number;
        case (sz)
            sqwb_pkg::SZ_1K: m = physical_page_number;
            sqwb_pkg::SZ_4K: m[11:10] = va[11:10];
            sqwb_pkg::SZ_64K: m[15:10] = va[15:10];
            default: m[19:10] = va[19:10];
        endcase
        return m;
    endfunction : pageMix

    always_comb begin
        // R9: page bits translated
        // R8: only page number used
        if (mmuOn) begin
            extAddr = {pageMix(tlbPpn, tlbSize, addr), addr[9:5]};
        end else begin
            // R10: direct bits, R12: high bits
            extAddr = {areaHi, addr[25:5]};
        end
        // R4: alignment checked first
        if (addr[1:0] != 2'h0 || (isQuad && addr[2])) begin
            exc = sqwb_pkg::EXC_ADDR;
        // R18: privilege beats translation
        // R19: user blocked when restricted
        end else if (privOnly && user) begin
            exc = sqwb_pkg::EXC_ADDR;
        // R17: write and read checks
        end else if (mmuOn && !tlbHit) begin
            exc = sqwb_pkg::EXC_MISS;
        end else if (mmuOn && !(isWrite ? tlbWrOk : tlbRdOk)) begin
            exc = sqwb_pkg::EXC_PROT;
        end else if (mmuOn && isWrite && !tlbDirty) begin
            exc = sqwb_pkg::EXC_INIT;
        end else begin
            exc = sqwb_pkg::EXC_NONE;
        end
    end
endmodule : sqwb_xlate

// file: tb/sqwb_mem_model.sv
`timescale 1ns/100ps
module sqwb_mem_model (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Burst from the block
    input wire logic memReq_r,
    input wire logic [28:0] memAddr_r,
    input wire logic [63:0] memData_r,
    input wire logic memLast_r,
    input wire logic [2:0] memSa_r,
    input wire logic memTc_r,
    input wire logic [3:0] stall,
    output logic memAck
);
    logic [3:0] waitCnt;
    logic [28:0] bAddr [32];
    logic [63:0] bData [32];
    logic [4:0] bAttr [32];
    int beatCnt;
    // Stall before each ack so that bursts overlap later core traffic
    always @(posedge clock) begin
        if (srst) begin
            memAck <= 1'b0;
            waitCnt <= 4'h0;
            beatCnt <= 0;
        end else if (memReq_r && memAck) begin
            bAddr[beatCnt[4:0]] <= memAddr_r;
            bData[beatCnt[4:0]] <= memData_r;
            bAttr[beatCnt[4:0]] <= {memLast_r, memTc_r, memSa_r};
            beatCnt <= beatCnt + 1;
            memAck <= 1'b0;
            waitCnt <= 4'h0;
        end else if (memReq_r) begin
            memAck <= (waitCnt >= stall);
            waitCnt <= waitCnt + 4'h1;
        end else begin
            memAck <= 1'b0;
        end
    end
endmodule : sqwb_mem_model

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic opReq = 1'b0;
    logic [1:0] opKind = 2'h0;
    logic [31:0] opAddr = 32'h0;
    logic [63:0] opData = 64'h0;
    logic opQuad = 1'b0, opUser = 1'b0, mmuOn = 1'b0, privOnly = 1'b0, tlbHit = 1'b1;
    logic [28:10] tlbPpn = 19'h12345;
    logic [1:0] tlbSize = 2'h0;
    logic tlbWrOk = 1'b1, tlbRdOk = 1'b1, tlbDirty = 1'b1, pteaTc = 1'b1, sqStopped = 1'b0;
    logic [2:0] pteaSa = 3'h3;
    logic [3:0] regAddr = 4'h0, stall = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0, regRd = 1'b0;
    logic opAck_r, memReq_r, memLast_r, memTc_r, memAck;
    logic [2:0] opExc_r, memSa_r;
    logic [31:0] opRdata_r, regRdata_r;
    logic [28:0] memAddr_r;
    logic [63:0] memData_r;
    logic [31:0] qRef [16], snap [16];
    int err_total = 0, cmp_count = 0, beatBase = 0;

    sqwb_top u_dut (.clock, .srst, .opReq, .opKind, .opAddr, .opData, .opQuad, .opUser, .opAck_r,
        .opExc_r, .opRdata_r, .mmuOn, .privOnly, .tlbHit, .tlbPpn, .tlbSize, .tlbWrOk, .tlbRdOk,
        .tlbDirty, .pteaSa, .pteaTc, .sqStopped, .regAddr, .regWdata, .regWr, .regRd, .regRdata_r,
        .memReq_r, .memAddr_r, .memData_r, .memLast_r, .memSa_r, .memTc_r, .memAck);
    sqwb_mem_model u_mem (.clock, .srst, .memReq_r, .memAddr_r, .memData_r, .memLast_r, .memSa_r,
        .memTc_r, .stall, .memAck);

    always #4 clock = ~clock;

    task automatic stop_test;
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1 chk(regRdata_r, exp);
    endtask : regRead

    // Core op held until acked; held ops simply wait longer
    task automatic doOp(input logic [1:0] k, input logic [31:0] a, input logic [63:0] d, input logic q,
                        input logic u, input logic [2:0] e);
        int n;
        n = 0;
        @(posedge clock);
        opReq <= 1'b1;
        opKind <= k;
        opAddr <= a;
        opData <= d;
        opQuad <= q;
        opUser <= u;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (opAck_r !== 1'b1 && n < 300);
        opReq <= 1'b0;
        if (opAck_r !== 1'b1) begin
            err_total++;
            stop_test();
        end
        chk(opExc_r, e);
        if (k == sqwb_pkg::OP_LOAD) chk(opRdata_r, qRef[a[5:2]]);
        if (k == sqwb_pkg::OP_STORE && e == sqwb_pkg::EXC_NONE) begin
            qRef[a[5:2]] = d[31:0];
            if (q) qRef[a[5:2] + 4'h1] = d[63:32];
        end
    endtask : doOp

    task automatic ldAll;
        for (int i = 0; i < 16; i++) begin
            doOp(sqwb_pkg::OP_LOAD, {sqwb_pkg::RB_REGION, 4'(i), 2'b00}, 64'h0, 1'b0, 1'b0, 3'h0);
        end
    endtask : ldAll

    task automatic chkBurst(input logic [28:0] base, input logic q, input logic [3:0] attr);
        int n;
        for (n = 0; n < 400 && u_mem.beatCnt < beatBase + 4; n++) @(posedge clock);
        if (n == 400) begin
            err_total++;
            stop_test();
        end
        for (int b = 0; b < 4; b++) begin
            chk(u_mem.bAddr[beatBase + b], base + 29'(8 * b)); // aligned beats
            chk(u_mem.bData[beatBase + b], {snap[{q, 2'(b), 1'b1}], snap[{q, 2'(b), 1'b0}]}); // whole queue
            chk(u_mem.bAttr[beatBase + b], {b == 3, attr}); // attributes
        end
        beatBase += 4;
    endtask : chkBurst

    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        regRead(sqwb_pkg::REG_QUEUE_ZERO_AREA_CONTROL, 32'h0); // reset value
        regWrite(sqwb_pkg::REG_QUEUE_ZERO_AREA_CONTROL, 32'h14);
        regWrite(sqwb_pkg::REG_QUEUE_ONE_AREA_CONTROL, 32'h8);
        regRead(4'hC, 32'h0); // unmapped reads zero
        regRead(sqwb_pkg::REG_STATUS, 32'h0); // idle status
        regRead(sqwb_pkg::REG_QUEUE_ONE_AREA_CONTROL, 32'h8); // own setting
        sqStopped <= 1'b1;
        regWrite(sqwb_pkg::REG_QUEUE_ZERO_AREA_CONTROL, 32'h1C);
        regRead(sqwb_pkg::REG_QUEUE_ZERO_AREA_CONTROL, 32'h0); // read blocked
        sqStopped <= 1'b0;
        regRead(sqwb_pkg::REG_QUEUE_ZERO_AREA_CONTROL, 32'h14); // write ignored
        for (int i = 0; i < 8; i++) begin
            doOp(2'h0, {6'h38, 21'h0, 3'(i), 2'b00}, {32'h0, 32'hA0000000 + i}, 1'b0, 1'b0, 3'h0);
            if (i < 4) doOp(2'h0, {6'h38, 21'h1, 2'(i), 3'h0}, {32'hB1000000 + i, 32'hB0000000 + i}, 1'b1, 1'b0, 3'h0);
        end
        ldAll; // readback
        doOp(sqwb_pkg::OP_LOAD, 32'hFF001000, 64'h0, 1'b0, 1'b1, sqwb_pkg::EXC_ADDR); // user load refused
        doOp(2'h3, 32'hE0000000, 64'h0, 1'b0, 1'b0, sqwb_pkg::EXC_ADDR); // unknown operation
        doOp(2'h0, 32'h40000000, 64'h1, 1'b0, 1'b0, sqwb_pkg::EXC_ADDR); // outside region
        doOp(2'h0, 32'hE0000002, 64'h1, 1'b0, 1'b0, sqwb_pkg::EXC_ADDR); // low bits set
        doOp(2'h0, 32'hE0000000, 64'hC0, 1'b0, 1'b1, 3'h0); // user allowed
        privOnly <= 1'b1;
        doOp(2'h0, 32'hE0000000, 64'h1, 1'b0, 1'b1, sqwb_pkg::EXC_ADDR); // user refused
        mmuOn <= 1'b1;
        doOp(2'h0, 32'hE0000004, 64'h1, 1'b0, 1'b1, sqwb_pkg::EXC_ADDR); // despite hit
        privOnly <= 1'b0;
        tlbWrOk <= 1'b0;
        doOp(2'h0, 32'hE0000004, 64'h1, 1'b0, 1'b0, sqwb_pkg::EXC_PROT); // write check
        tlbWrOk <= 1'b1;
        tlbDirty <= 1'b0;
        doOp(2'h0, 32'hE0000004, 64'h1, 1'b0, 1'b0, sqwb_pkg::EXC_INIT); // first write
        tlbDirty <= 1'b1;
        tlbRdOk <= 1'b0;
        doOp(sqwb_pkg::OP_PREFETCH_OP, 32'hE0000000, 64'h0, 1'b0, 1'b0, sqwb_pkg::EXC_PROT); // read check
        tlbRdOk <= 1'b1;
        tlbHit <= 1'b0;
        doOp(sqwb_pkg::OP_PREFETCH_OP, 32'hE0000000, 64'h0, 1'b0, 1'b0, sqwb_pkg::EXC_MISS); // miss
        ldAll; // contents kept
        chk(u_mem.beatCnt, 0); // no external write
        tlbHit <= 1'b1;
        snap = qRef;
        doOp(sqwb_pkg::OP_PREFETCH_OP, {6'h38, 20'h00013, 1'b0, 3'h5, 2'b00}, 64'h0, 1'b0, 1'b0, 3'h0);
        chkBurst({19'h12345, 5'h06, 5'h0}, 1'b0, 4'h0); // translated
        mmuOn <= 1'b0;
        doOp(sqwb_pkg::OP_PREFETCH_OP, {6'h38, 20'hABCDE, 1'b0, 3'h7, 2'b00}, 64'h0, 1'b0, 1'b0, 3'h0);
        chkBurst({3'h5, 20'hABCDE, 1'b0, 5'h0}, 1'b0, 4'hB); // card area
        stall <= 4'h4;
        doOp(sqwb_pkg::OP_PREFETCH_OP, {6'h38, 20'h12345, 1'b1, 3'h0, 2'b00}, 64'h0, 1'b0, 1'b0, 3'h0);
        regRead(sqwb_pkg::REG_STATUS, 32'h3); // queue one under burst
        doOp(2'h0, 32'hE0000000, 64'hD0, 1'b0, 1'b0, 3'h0);
        chk(u_mem.beatCnt < beatBase + 4, 1'b1); // other queue free
        doOp(2'h0, 32'hE0000020, 64'hD1, 1'b0, 1'b0, 3'h0);
        chk(u_mem.beatCnt, beatBase + 4); // busy queue deferred
        chkBurst({3'h2, 20'h12345, 1'b1, 5'h0}, 1'b1, 4'h0); // old contents sent
        ldAll; // both stores landed
        stop_test();
    end
endmodule : tb_top
